// File: uihc_pkg.sv
package uihc_pkg;
  // register offsets (byte port, own map)
  localparam logic [3:0] ADDR_INPUT_CHANGE_STATUS = 4'h0;
  localparam logic [3:0] ADDR_AUX_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_BAUD_PRELOAD_HIGH = 4'h4;
  localparam logic [3:0] ADDR_BAUD_PRELOAD_LOW = 4'h5;
  localparam logic [3:0] ADDR_IRQ_VECTOR = 4'h6;
  localparam logic [3:0] ADDR_INPUT_PORT_LEVEL = 4'h7;
  localparam logic [3:0] ADDR_OUTPUT_PORT_SET = 4'h8;
  localparam logic [3:0] ADDR_OUTPUT_PORT_CLEAR = 4'h9;
  localparam logic [3:0] ADDR_BREAK_CMD = 4'ha;
  // field positions
  localparam int BIT_COS = 7;
  localparam int BIT_DB = 2;
  localparam int BIT_RX = 1;
  localparam int BIT_TX = 0;
  localparam int BIT_CHG_COS = 4;
  localparam int BIT_IEC = 0;
  localparam int BIT_RTS = 0;
  localparam int BIT_RX_SEL = 6;
  // reset values
  localparam logic [7:0] RST_IRQ_VECTOR = 8'h0f;
  localparam logic [7:0] RST_CHANGE_FIXED = 8'h0e;
  localparam logic [15:0] RST_BAUD_PRELOAD = 16'h0002;
  localparam logic [15:0] MIN_BAUD_PRELOAD = 16'h0002;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int FILTER_US = 25;
  localparam int FILTER_CYCLES = FILTER_US * CLK_MHZ;
  localparam logic [10:0] FILTER_LAST = 11'(FILTER_CYCLES - 1);
  localparam int STARTUP_SCLK = 2;
  localparam logic [1:0] STARTUP_LAST = 2'(STARTUP_SCLK);

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uihc_bus_t;

  typedef struct packed {
    logic rx_char_avail;
    logic rx_queue_full;
    logic tx_hold_empty;
    logic break_edge;
  } uihc_chan_t;
endpackage

// File: uihc_ctrl.sv
// Contract
// - filtered cts edge sets change flag
// - change register read clears both change flags
// - tracking starts two serial clocks after reset
// - enable gates change into status bit 7
// - enable is aux control bit 0
// - interrupt is or of status and mask
// - status reads unmasked
// - reset clears change and break status bits 7 and 2; rx and tx bits follow the channel inputs
// - break start or end sets break flag
// - break reset command clears break flag
// - rx status bit follows mode select
// - tx status bit mirrors holding empty
// - mask holds four source enables
// - 16-bit write-only preload, minimum 2 (not enforced: writes below 2 pass to O_BAUD_PRELOAD unchanged)
// - vector register resets to 0f
// - input port reads current cts level
// - set address writes one assert rts
// - clear address writes one negate rts
// - rts pin driven inverted
`timescale 1ns/10ps
`default_nettype none
module uihc_ctrl (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_SCLK_EN,
  input wire uihc_pkg::uihc_bus_t I_BUS,
  input wire uihc_pkg::uihc_chan_t I_CHAN,
  input wire logic I_RX_SEL_FULL,
  input wire logic I_CTS_B,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  output logic O_RTS_B,
  output logic [7:0] O_VECTOR,
  output logic [15:0] O_BAUD_PRELOAD,
  output logic [1:0] O_TIMER_SEL
);
  import uihc_pkg::*;

  typedef enum logic [1:0] {ST_WAIT, ST_RUN} uihc_state_t;

  logic cts_meta, cts_sync, cts_filt, cts_state;
  logic [10:0] filt_cnt;
  logic [1:0] start_cnt;
  uihc_state_t state;
  logic chg_cos, cos_stat, db_stat, rts;
  logic [7:0] aux, mask, vec, baud_hi, baud_lo;
  logic brk_d;

  wire wr = I_BUS.wr;
  wire rd = I_BUS.rd;
  wire [3:0] a = I_BUS.addr;
  wire [7:0] wd = I_BUS.wdata;
  wire rd_change = rd && (a == ADDR_INPUT_CHANGE_STATUS);
  wire running = (state == ST_RUN);
  wire cts_level = cts_state;
  wire filt_edge = (cts_sync != cts_filt) && (filt_cnt == FILTER_LAST);
  wire first_track = (state == ST_WAIT) && I_SCLK_EN && (start_cnt == STARTUP_LAST - 2'h1);
  wire cos_event = (running && filt_edge) || (first_track && !cts_filt);
  wire iec = aux[BIT_IEC];
  wire brk_event = I_CHAN.break_edge ^ brk_d;
  wire brk_clear = wr && (a == ADDR_BREAK_CMD);
  wire rx_stat = I_RX_SEL_FULL ? I_CHAN.rx_queue_full : I_CHAN.rx_char_avail;
  wire [7:0] status = {cos_stat, 4'h0, db_stat, rx_stat, I_CHAN.tx_hold_empty};
  wire [7:0] change_reg = {3'h0, chg_cos, 3'h7, cts_level};
  wire [7:0] mask_eff = mask & 8'h87;
  wire next_irq = |(status & mask_eff);
  logic [7:0] next_rdata;
  always_comb begin
    unique case (a)
      ADDR_INPUT_CHANGE_STATUS: next_rdata = change_reg;
      ADDR_AUX_CONTROL: next_rdata = aux;
      ADDR_IRQ_STATUS: next_rdata = status;
      ADDR_IRQ_MASK: next_rdata = mask;
      ADDR_IRQ_VECTOR: next_rdata = vec;
      ADDR_INPUT_PORT_LEVEL: next_rdata = {7'h0, cts_level};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
    end else begin
      cts_meta <= I_CTS_B;
      cts_sync <= cts_meta;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cts_filt <= 1'b1;
      filt_cnt <= 11'h000;
    end else if (cts_sync == cts_filt) begin
      filt_cnt <= 11'h000;
    end else if (filt_cnt == FILTER_LAST) begin
      cts_filt <= cts_sync;
      filt_cnt <= 11'h000;
    end else begin
      filt_cnt <= filt_cnt + 11'h001;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state <= ST_WAIT;
      start_cnt <= 2'h0;
      cts_state <= 1'b1;
    end else begin
      unique case (state)
        ST_WAIT: if (I_SCLK_EN) begin
          start_cnt <= start_cnt + 2'h1;
          if (first_track) begin
            state <= ST_RUN;
            cts_state <= cts_filt;
          end
        end
        ST_RUN: cts_state <= filt_edge ? cts_sync : cts_filt;
        default: state <= ST_WAIT;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      chg_cos <= 1'b0;
      cos_stat <= 1'b0;
      db_stat <= 1'b0;
      brk_d <= 1'b0;
    end else begin
      brk_d <= I_CHAN.break_edge;
      chg_cos <= cos_event | (chg_cos & ~rd_change);
      cos_stat <= (cos_event & iec) | (cos_stat & ~rd_change);
      db_stat <= brk_event | (db_stat & ~brk_clear);
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      aux <= 8'h00;
      mask <= 8'h00;
      vec <= RST_IRQ_VECTOR;
      baud_hi <= RST_BAUD_PRELOAD[15:8];
      baud_lo <= RST_BAUD_PRELOAD[7:0];
      rts <= 1'b0;
    end else if (wr) begin
      if (a == ADDR_AUX_CONTROL) aux <= wd;
      if (a == ADDR_IRQ_MASK) mask <= wd;
      if (a == ADDR_IRQ_VECTOR) vec <= wd;
      if (a == ADDR_BAUD_PRELOAD_HIGH) baud_hi <= wd;
      if (a == ADDR_BAUD_PRELOAD_LOW) baud_lo <= wd;
      if (a == ADDR_OUTPUT_PORT_SET && wd[BIT_RTS]) rts <= 1'b1;
      if (a == ADDR_OUTPUT_PORT_CLEAR && wd[BIT_RTS]) rts <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RDATA <= 8'h00;
      O_IRQ <= 1'b0;
      O_RTS_B <= 1'b1;
      O_VECTOR <= RST_IRQ_VECTOR;
      O_BAUD_PRELOAD <= RST_BAUD_PRELOAD;
      O_TIMER_SEL <= 2'h0;
    end else begin
      O_RDATA <= rd ? next_rdata : 8'h00;
      O_IRQ <= next_irq;
      O_RTS_B <= ~rts;
      O_VECTOR <= vec;
      O_BAUD_PRELOAD <= {baud_hi, baud_lo};
      O_TIMER_SEL <= aux[6:5];
    end
  end

  // checks
  cos_sets_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    cos_event |=> chg_cos) else $error("change flag not set");
  read_clr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    rd_change && !cos_event |=> !chg_cos && !cos_stat) else $error("read did not clear");
  iec_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    !iec && !cos_stat |=> !cos_stat) else $error("status set while disabled");
  irq_out_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    ##1 O_IRQ == $past(next_irq)) else $error("irq mismatch");
  stat_read_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    rd && a == ADDR_IRQ_STATUS |=> O_RDATA == $past(status)) else $error("status read wrong");
  brk_clr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    brk_clear && !brk_event |=> !db_stat) else $error("break not cleared");
  rts_set_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    wr && a == ADDR_OUTPUT_PORT_SET && wd[0] |=> ##1 !O_RTS_B) else $error("rts not asserted");
  rts_clr_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    wr && a == ADDR_OUTPUT_PORT_CLEAR && wd[0] |=> ##1 O_RTS_B) else $error("rts not negated");
  filt_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    cts_sync == cts_filt |=> filt_cnt == 11'h000) else $error("filter count stuck");
  cos_irq_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_B) cos_stat && O_IRQ);
  brk_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_B) db_stat ##1 brk_clear);
  start_c: cover property (@(posedge I_CLOCK) disable iff (!I_RST_B) first_track && !cts_filt);
endmodule
`default_nettype wire

// File: uihc_remote.sv
`timescale 1ns/10ps
`default_nettype none
module uihc_remote #(parameter int DELAY = 8) (
  input wire logic i_clk,
  input wire logic i_rts_b,
  output logic o_cts_b
);
  int cnt = 0;
  initial o_cts_b = 1'b1;
  // clear-to-send follows request-to-send DELAY+1 cycles after the two differ
  always @(posedge i_clk) begin
    if (o_cts_b == i_rts_b) cnt <= 0;
    else if (cnt == DELAY) o_cts_b <= i_rts_b;
    else cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

// File: uart_irq_handshake_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module uart_irq_handshake_ctrl_test;
  import uihc_pkg::*;
  logic clk = 0, rst_b = 0, sclk_en = 0, rx_sel = 0, rd_d = 0, db = 0, pb = 0, irq, rts_b;
  wire logic cts_b;
  uihc_bus_t bus = '0;
  uihc_chan_t chan = '0;
  logic [7:0] rdata, vec, m, x;
  logic [15:0] pre, q;
  logic [1:0] tsel;
  logic [31:0] r;
  logic [15:0] expq[$];
  int mismatches = 0, samples_checked = 0, cyc = 0;
  uihc_ctrl DUT (.I_CLOCK(clk), .I_RST_B(rst_b), .I_SCLK_EN(sclk_en), .I_BUS(bus),
    .I_CHAN(chan), .I_RX_SEL_FULL(rx_sel), .I_CTS_B(cts_b), .O_RDATA(rdata), .O_IRQ(irq),
    .O_RTS_B(rts_b), .O_VECTOR(vec), .O_BAUD_PRELOAD(pre), .O_TIMER_SEL(tsel));
  uihc_remote #(.DELAY(8)) far_end (.i_clk(clk), .i_rts_b(rts_b), .o_cts_b(cts_b));
  initial forever #10 clk = ~clk;
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task summarize;
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] mk);
    expq.push_back({mk, e});
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask
  // read data checked in the cycle after the strobe
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sclk_en <= cyc[1:0] == 2'h0;
    rd_d <= bus.rd;
    if (rd_d) begin
      q = expq.pop_front();
      check("rdata", {8'h00, rdata & q[15:8]}, {8'h00, q[7:0]});
    end
    if (cyc == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h6caafad4));
    step(4);
    rst_b <= 1'b1;
    step(1);
    check("vector", {8'h00, vec}, {8'h00, RST_IRQ_VECTOR});
    check("preload", pre, RST_BAUD_PRELOAD);
    step(12);
    rd(4'h0, RST_CHANGE_FIXED | 8'h01, 8'hff);
    rd(4'h2, 8'h00, 8'hff);
    rd(4'h6, RST_IRQ_VECTOR, 8'hff);
    wr(4'h6, 8'h40);
    wr(4'h3, 8'h80);
    wr(4'h1, 8'h41);
    wr(4'h4, 8'h12);
    wr(4'h5, 8'h34);
    rd(4'h5, 8'h00, 8'hff);
    rd(4'hf, 8'h00, 8'hff);
    rd(4'h1, 8'h41, 8'hff);
    rd(4'h3, 8'h80, 8'hff);
    step(2);
    check("vector", {8'h00, vec}, 16'h0040);
    check("preload", pre, 16'h1234);
    check("timer", {14'h0, tsel}, 16'h0002);
    wr(4'h8, 8'h00);
    step(2);
    check("rts", {15'h0, rts_b}, 16'h0001);
    wr(4'h8, 8'h01);
    wr(4'h9, 8'h00);
    step(2);
    check("rts", {15'h0, rts_b}, 16'h0000);
    step(1400);
    rd(4'h2, 8'h80, 8'h80);
    step(2);
    check("irq", {15'h0, irq}, 16'h0001);
    rd(4'h0, 8'h1e, 8'hff);
    rd(4'h7, 8'h00, 8'h01);
    rd(4'h2, 8'h00, 8'h80);
    step(2);
    check("irq", {15'h0, irq}, 16'h0000);
    wr(4'h1, 8'h00);
    wr(4'h9, 8'h01);
    step(2);
    check("rts", {15'h0, rts_b}, 16'h0001);
    step(1400);
    rd(4'h0, 8'h1f, 8'hff);
    rd(4'h2, 8'h00, 8'h80);
    // random channel flags, mode select and mask
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      m = r[15:8] & 8'h87;
      wr(4'h3, m);
      chan <= r[3:0];
      rx_sel <= r[4];
      db = db | (r[0] ^ pb);
      pb = r[0];
      x = {5'h0, db, r[4] ? r[2] : r[3], r[1]};
      step(3);
      rd(4'h2, x, 8'h87);
      step(2);
      check("irq", {15'h0, irq}, {15'h0, |(m & x)});
      if (r[5]) begin
        wr(4'ha, 8'h00);
        db = 1'b0;
      end
    end
    step(4);
    summarize();
  end
endmodule
`default_nettype wire
